// ---- core/adc_module_end.sv ----
/*
  converter module end: oversampled and multiplexed acquisition.
  assumes the chassis end holds req until it sees smp_last.
*/
// Operation
// - oversample tick at 12 MHz or faster
// - bitstream feeds decimator and 1-bit feedback
// - start event resets oversample timing
// - no data before first-data latency
// - discrete rates from integer oversample divisors
// - unsupported rate rounds up, not rejected
// - read waits for full sample period
// - one module exports tick, others import
// - export choice fixed at build time
// - channels share one converter, one by one
// - per-channel rate is aggregate over selection
// - fixed delay between successive channel samples
// - fast pipeline primes over two conversions
// - channels sampled in ascending number order
// - new leading pair reloads pipeline, two slots
// - low-level reader discards first two samples
// - slow module has no conversion pipeline
`include "seq_defs.svh"
`default_nettype none

module adc_module_end
  import seq_pkg::*;
#(
  parameter bit osc_export = 1'b1,
  parameter int slow_conv_cyc = `MUX_SLOW_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link to chassis logic
  seq_link_if.dev link,
  // shared oversample tick
  input wire logic osc_in,
  output logic osc_out,
  // analog front end, already digitised
  input wire seq_pkg::ain_t ain [`NCH]
);
  import seq_pkg::*;

  typedef enum {M_IDLE, M_RELOAD, M_SWEEP} mux_e;

  logic [1:0] osc_cnt_reg, osc_cnt_next;
  rate_e rate_reg, rate_next;
  logic [8:0] tick_cnt_reg, tick_cnt_next;
  logic [1:0] lat_reg, lat_next;
  logic started_reg, started_next;
  mux_e mst_reg, mst_next;
  logic [16:0] slot_reg, slot_next;
  logic [3:0] mask_reg, mask_next;
  logic [1:0] cur_reg, cur_next;
  logic [1:0] rel_reg, rel_next;
  logic [3:0] held_reg, held_next;
  logic held_ok_reg, held_ok_next;
  ain_t samp_reg, samp_next;
  logic stb_reg, stb_next;
  data_t data_reg, data_next;
  logic [1:0] chan_reg, chan_next;
  logic ok_reg, ok_next;
  logic last_reg, last_next;
  logic osc_tick, period_end, slot_end, res_stb;
  logic [8:0] result;
  logic [16:0] slot_lim;
  logic [2:0] f0, f1, fn;
  logic [3:0] pair;

  // local divider drives the tick only when this module is the source
  assign osc_tick = osc_export ? (osc_cnt_reg == 2'h0) : osc_in;
  assign osc_out = osc_export ? (osc_cnt_reg == 2'h0) : 1'b0;
  assign period_end = osc_tick && started_reg
                      && tick_cnt_reg == rate_div(rate_reg) - 9'h001;
  assign slot_lim = link.fast ? 17'(`MUX_FAST_CYC - 1)
                              : 17'(slow_conv_cyc - 1);
  assign slot_end = slot_reg == slot_lim;
  assign f0 = first_at(link.chans, 3'h0);
  assign f1 = first_at(link.chans, {1'b0, f0[1:0]} + 3'h1);
  assign pair = {f1[1:0], f0[1:0]};
  assign fn = first_at(mask_reg, {1'b0, cur_reg} + 3'h1);

  ds_modulator u_mod (
    .clk(clk),
    .reset(reset),
    .clr(link.start),
    .en(osc_tick && started_reg),
    .dump(period_end),
    .vin(ain[0]),
    .result(result),
    .res_stb(res_stb)
  );

  always_comb begin
    osc_cnt_next = osc_cnt_reg;
    rate_next = rate_reg;
    tick_cnt_next = tick_cnt_reg;
    lat_next = lat_reg;
    started_next = started_reg;
    if (osc_cnt_reg == 2'(`OSC_DIV - 1)) osc_cnt_next = 2'h0;
    else osc_cnt_next = osc_cnt_reg + 2'h1;
    if (link.start) begin
      osc_cnt_next = 2'h0;
      tick_cnt_next = 9'h000;
      lat_next = 2'h0;
      started_next = 1'b1;
      rate_next = round_rate(link.rate_req);
    end else if (osc_tick && started_reg) begin
      if (period_end) begin
        tick_cnt_next = 9'h000;
      end else begin
        tick_cnt_next = tick_cnt_reg + 9'h001;
      end
    end
    // count a period once its word exists, so each word is judged
    // by the periods finished before it
    if (!link.start && res_stb && lat_reg != `LAT_PERIODS) begin
      lat_next = lat_reg + 2'h1;
    end
  end

  always_comb begin
    mst_next = mst_reg;
    slot_next = slot_reg;
    mask_next = mask_reg;
    cur_next = cur_reg;
    rel_next = rel_reg;
    held_next = held_reg;
    held_ok_next = held_ok_reg;
    samp_next = samp_reg;
    stb_next = 1'b0;
    data_next = data_reg;
    chan_next = chan_reg;
    ok_next = ok_reg;
    last_next = 1'b0;
    // oversampled read answers only at a period boundary
    if (!link.mux_mode && link.req && !last_reg && res_stb) begin
      stb_next = 1'b1;
      data_next = data_t'(result);
      chan_next = 2'h0;
      ok_next = lat_reg == `LAT_PERIODS;
      last_next = 1'b1;
    end
    case (mst_reg)
      M_IDLE: begin
        slot_next = 17'h00000;
        if (link.mux_mode && link.req && !last_reg) begin
          mask_next = link.chans;
          cur_next = f0[1:0];
          rel_next = 2'h0;
          if (!f0[2]) begin
            // empty selection answers at once, flagged invalid
            stb_next = 1'b1;
            ok_next = 1'b0;
            last_next = 1'b1;
          end else if (link.fast && !(held_ok_reg && held_reg == pair))
          begin
            mst_next = M_RELOAD;
            held_next = pair;
            held_ok_next = 1'b1;
          end else begin
            mst_next = M_SWEEP;
          end
        end
      end
      M_RELOAD: begin
        slot_next = slot_end ? 17'h00000 : slot_reg + 17'h00001;
        if (slot_end) begin
          stb_next = 1'b1;
          chan_next = rel_reg;
          ok_next = 1'b0;
          rel_next = rel_reg + 2'h1;
          if (rel_reg == `RELOAD_SLOTS - 2'h1) mst_next = M_SWEEP;
        end
      end
      M_SWEEP: begin
        if (slot_reg == 17'h00000) samp_next = ain[cur_reg];
        slot_next = slot_end ? 17'h00000 : slot_reg + 17'h00001;
        if (slot_end) begin
          stb_next = 1'b1;
          data_next = data_t'(samp_reg);
          chan_next = cur_reg;
          ok_next = 1'b1;
          if (fn[2]) begin
            cur_next = fn[1:0];
          end else begin
            last_next = 1'b1;
            mst_next = M_IDLE;
          end
        end
      end
      default: mst_next = M_IDLE;
    endcase
    if (link.start) begin
      // start clears pipeline ownership so the next fast read re-primes
      held_ok_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_cnt_reg <= 2'h0;
      rate_reg <= RATE_LO;
      tick_cnt_reg <= 9'h000;
      lat_reg <= 2'h0;
      started_reg <= 1'b0;
    end else begin
      osc_cnt_reg <= osc_cnt_next;
      rate_reg <= rate_next;
      tick_cnt_reg <= tick_cnt_next;
      lat_reg <= lat_next;
      started_reg <= started_next;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mst_reg <= M_IDLE;
      slot_reg <= 17'h00000;
      mask_reg <= 4'h0;
      cur_reg <= 2'h0;
      rel_reg <= 2'h0;
      held_reg <= 4'h0;
      held_ok_reg <= 1'b0;
      samp_reg <= 12'sh000;
      stb_reg <= 1'b0;
      data_reg <= 16'h0000;
      chan_reg <= 2'h0;
      ok_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      mst_reg <= mst_next;
      slot_reg <= slot_next;
      mask_reg <= mask_next;
      cur_reg <= cur_next;
      rel_reg <= rel_next;
      held_reg <= held_next;
      held_ok_reg <= held_ok_next;
      samp_reg <= samp_next;
      stb_reg <= stb_next;
      data_reg <= data_next;
      chan_reg <= chan_next;
      ok_reg <= ok_next;
      last_reg <= last_next;
    end
  end

  assign link.smp_stb = stb_reg;
  assign link.smp_data = data_reg;
  assign link.smp_chan = chan_reg;
  assign link.smp_ok = ok_reg;
  assign link.smp_last = last_reg;
endmodule // adc_module_end

`default_nettype wire

// ---- core/seq_defs.svh ----
/*
  timing counts, rate divisors and widths for the sample sequencer ends.
  assumes a 50 MHz system clock shared by both ends.
*/
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

`define CLK_HZ 50000000
`define OSC_MIN_HZ 12000000
// floor keeps the oversample tick at or above the minimum rate
`define OSC_DIV (`CLK_HZ / `OSC_MIN_HZ)
`define OSC_HZ (`CLK_HZ / `OSC_DIV)

`define DIV_HI 9'h040
`define DIV_MID 9'h080
`define DIV_LO 9'h100
`define RATE_HI_HZ (`OSC_HZ / 64)
`define RATE_MID_HZ (`OSC_HZ / 128)
`define RATE_LO_HZ (`OSC_HZ / 256)

`define LAT_PERIODS 2'h3
`define RELOAD_SLOTS 2'h2

`define MUX_FAST_AGG_HZ 250000
`define MUX_FAST_CYC (`CLK_HZ / `MUX_FAST_AGG_HZ)
`define MUX_SLOW_AGG_HZ 500
`define MUX_SLOW_CYC (`CLK_HZ / `MUX_SLOW_AGG_HZ)

`define NCH 4
`define DW 16
`define AW 12
`define RATE_W 18
`define MOD_REF 14'sh0800

`endif

// ---- core/seq_pkg.sv ----
/*
  types and shared decode functions for the sample sequencer.
  assumes seq_defs.svh is on the include path.
*/
`include "seq_defs.svh"
`default_nettype none

package seq_pkg;
  typedef enum logic [1:0] {RATE_HI, RATE_MID, RATE_LO} rate_e;
  typedef logic signed [`AW-1:0] ain_t;
  typedef logic [`DW-1:0] data_t;

  function automatic logic [8:0] rate_div(input rate_e r);
    case (r)
      RATE_HI: rate_div = `DIV_HI;
      RATE_MID: rate_div = `DIV_MID;
      default: rate_div = `DIV_LO;
    endcase
  endfunction

  // unsupported requests go to the next higher rate; above the top, top
  function automatic rate_e round_rate(input logic [`RATE_W-1:0] hz);
    if (32'(hz) <= `RATE_LO_HZ) round_rate = RATE_LO;
    else if (32'(hz) <= `RATE_MID_HZ) round_rate = RATE_MID;
    else round_rate = RATE_HI;
  endfunction

  // lowest selected channel at or above from: {found, index}
  function automatic logic [2:0] first_at(input logic [3:0] m,
                                          input logic [2:0] from);
    first_at = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (3'(i) >= from && m[i]) first_at = {1'b1, 2'(i)};
    end
  endfunction
endpackage

`default_nettype wire

// ---- core/seq_link_if.sv ----
/*
  request/sample link between chassis logic and the converter module.
  assumes both ends run on the same clock.
*/
`include "seq_defs.svh"
`default_nettype none

interface seq_link_if;
  logic start;
  logic req;
  logic [3:0] chans;
  logic [`RATE_W-1:0] rate_req;
  logic mux_mode;
  logic fast;
  logic smp_stb;
  seq_pkg::data_t smp_data;
  logic [1:0] smp_chan;
  logic smp_ok;
  logic smp_last;

  modport dev (input start, req, chans, rate_req, mux_mode, fast,
               output smp_stb, smp_data, smp_chan, smp_ok, smp_last);
  modport host (output start, req, chans, rate_req, mux_mode, fast,
                input smp_stb, smp_data, smp_chan, smp_ok, smp_last);
endinterface

`default_nettype wire

// ---- core/ds_modulator.sv ----
/*
  first-order modulator with ones-counting decimator.
  assumes en is the oversample tick and dump ends a sample period.
*/
`default_nettype none

module ds_modulator
  import seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic clr,
  input wire logic en,
  input wire logic dump,
  input wire seq_pkg::ain_t vin,
  // result
  output logic [8:0] result,
  output logic res_stb
);
  import seq_pkg::*;

  logic signed [13:0] integ_reg, integ_next;
  logic [8:0] ones_reg, ones_next;
  logic [8:0] result_reg, result_next;
  logic stb_reg, stb_next;
  logic bit_now;

  assign bit_now = ~integ_reg[13];

  always_comb begin
    integ_next = integ_reg;
    ones_next = ones_reg;
    result_next = result_reg;
    stb_next = 1'b0;
    if (clr) begin
      integ_next = 14'sh0000;
      ones_next = 9'h000;
    end else if (en) begin
      // 1-bit feedback pulls the running difference back toward zero
      integ_next = integ_reg + 14'(vin)
                   - (bit_now ? `MOD_REF : -`MOD_REF);
      if (dump) begin
        result_next = ones_reg + 9'(bit_now);
        ones_next = 9'h000;
        stb_next = 1'b1;
      end else begin
        ones_next = ones_reg + 9'(bit_now);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      integ_reg <= 14'sh0000;
      ones_reg <= 9'h000;
      result_reg <= 9'h000;
      stb_reg <= 1'b0;
    end else begin
      integ_reg <= integ_next;
      ones_reg <= ones_next;
      result_reg <= result_next;
      stb_reg <= stb_next;
    end
  end

  assign result = result_reg;
  assign res_stb = stb_reg;
endmodule // ds_modulator

`default_nettype wire

// ---- core/chassis_end.sv ----
/*
  chassis-side caller: sends start, holds read requests, filters samples.
  assumes the module end answers every request with one smp_last.
*/
`include "seq_defs.svh"
`default_nettype none

module chassis_end
  import seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // user command side
  input wire logic usr_start,
  input wire logic usr_read,
  input wire logic [3:0] usr_chans,
  input wire logic [`RATE_W-1:0] usr_rate,
  input wire logic usr_mux,
  input wire logic usr_fast,
  input wire logic usr_lowlevel,
  // user sample side
  output logic usr_stb,
  output seq_pkg::data_t usr_data,
  output logic [1:0] usr_chan,
  output logic usr_busy,
  // link to module
  seq_link_if.host link
);
  import seq_pkg::*;

  typedef enum {H_IDLE, H_WAIT} host_e;

  host_e st_reg, st_next;
  logic started_reg, started_next;
  logic start_reg, start_next;
  logic [3:0] chans_reg, chans_next;
  logic [`RATE_W-1:0] rate_reg, rate_next;
  logic mux_reg, mux_next;
  logic fast_reg, fast_next;
  logic low_reg, low_next;
  logic [1:0] drop_reg, drop_next;
  logic stb_reg, stb_next;
  data_t data_reg, data_next;
  logic [1:0] chan_reg, chan_next;
  logic keep;

  // low-level reads trust nothing until two samples have gone by
  assign keep = low_reg ? (drop_reg == 2'h2) : link.smp_ok;

  always_comb begin
    st_next = st_reg;
    started_next = started_reg;
    start_next = 1'b0;
    chans_next = chans_reg;
    rate_next = rate_reg;
    mux_next = mux_reg;
    fast_next = fast_reg;
    low_next = low_reg;
    drop_next = drop_reg;
    stb_next = 1'b0;
    data_next = data_reg;
    chan_next = chan_reg;
    case (st_reg)
      H_IDLE: begin
        if (usr_start) begin
          start_next = 1'b1;
          started_next = 1'b1;
          rate_next = usr_rate;
        end else if (usr_read && (usr_mux || started_reg)) begin
          st_next = H_WAIT;
          chans_next = usr_chans;
          mux_next = usr_mux;
          fast_next = usr_fast;
          low_next = usr_lowlevel && usr_mux && usr_fast;
          drop_next = 2'h0;
        end
      end
      H_WAIT: begin
        if (link.smp_stb) begin
          if (keep) begin
            stb_next = 1'b1;
            data_next = link.smp_data;
            chan_next = link.smp_chan;
          end
          if (drop_reg != 2'h2) drop_next = drop_reg + 2'h1;
          if (link.smp_last) st_next = H_IDLE;
        end
      end
      default: st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= H_IDLE;
      started_reg <= 1'b0;
      start_reg <= 1'b0;
      chans_reg <= 4'h0;
      rate_reg <= '0;
      mux_reg <= 1'b0;
      fast_reg <= 1'b0;
      low_reg <= 1'b0;
      drop_reg <= 2'h0;
      stb_reg <= 1'b0;
      data_reg <= 16'h0000;
      chan_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      started_reg <= started_next;
      start_reg <= start_next;
      chans_reg <= chans_next;
      rate_reg <= rate_next;
      mux_reg <= mux_next;
      fast_reg <= fast_next;
      low_reg <= low_next;
      drop_reg <= drop_next;
      stb_reg <= stb_next;
      data_reg <= data_next;
      chan_reg <= chan_next;
    end
  end

  assign link.start = start_reg;
  assign link.req = st_reg == H_WAIT;
  assign link.chans = chans_reg;
  assign link.rate_req = rate_reg;
  assign link.mux_mode = mux_reg;
  assign link.fast = fast_reg;
  assign usr_stb = stb_reg;
  assign usr_data = data_reg;
  assign usr_chan = chan_reg;
  assign usr_busy = st_reg != H_IDLE;
endmodule // chassis_end

`default_nettype wire

// ---- bench/seq_link_assertions.sv ----
/*
  concurrent checks on the link between chassis end and module end.
  assumes one clock for both ends and an active high async reset.
*/
`default_nettype none

module seq_link_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link, host side
  input wire logic start,
  input wire logic req,
  input wire logic [3:0] chans,
  input wire logic mux_mode,
  input wire logic fast,
  // link, module side
  input wire logic smp_stb,
  input wire logic [1:0] smp_chan,
  input wire logic smp_ok,
  input wire logic smp_last
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  // oversampled answers since start, saturating at the latency of three
  logic [1:0] ans_reg, ans_next;
  // cycles since last strobe; saturates so idle spans never wrap
  logic [15:0] gap_reg, gap_next;
  // last valid channel of this request, with a seen flag
  logic [2:0] prev_reg, prev_next;

  always_comb begin
    ans_next = ans_reg;
    gap_next = gap_reg;
    prev_next = prev_reg;
    if (start)
      ans_next = 2'h0;
    else if (smp_stb && !mux_mode && ans_reg != 2'h3)
      ans_next = ans_reg + 2'h1;
    if (smp_stb)
      gap_next = 16'h0000;
    else if (gap_reg != 16'hFFFF)
      gap_next = gap_reg + 16'h0001;
    if (smp_stb && smp_last)
      prev_next = 3'h0;
    else if (smp_stb && smp_ok)
      prev_next = {1'b1, smp_chan};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ans_reg <= 2'h0;
      gap_reg <= 16'hFFFF;
      prev_reg <= 3'h0;
    end else begin
      ans_reg <= ans_next;
      gap_reg <= gap_next;
      prev_reg <= prev_next;
    end
  end

  sequence ans_s;
    smp_stb && smp_last;
  endsequence
  sequence os_ans_s;
    smp_stb && !mux_mode;
  endsequence

  last_with_stb_a: assert property (smp_last |-> smp_stb)
    else $error("last flag without a sample");
  stb_single_a: assert property (smp_stb |=> !smp_stb)
    else $error("sample strobe longer than one cycle");
  stb_needs_req_a: assert property (smp_stb |-> req)
    else $error("sample without a request");
  req_hold_a: assert property (req && !smp_last |=> req)
    else $error("request dropped before last sample");
  req_release_a: assert property (ans_s |=> !req)
    else $error("request kept after last sample");
  first_data_a: assert property (os_ans_s ##0 ans_reg != 2'h3
    |-> !smp_ok)
    else $error("valid word inside first-data latency");
  settled_ok_a: assert property (os_ans_s ##0 ans_reg == 2'h3
    |-> smp_ok)
    else $error("settled word flagged invalid");
  period_span_a: assert property (os_ans_s |-> gap_reg >= 16'h00FF)
    else $error("oversampled words closer than a period");
  os_word_a: assert property (os_ans_s |-> smp_last && smp_chan == 2'h0)
    else $error("oversampled answer not a single word");
  fast_slot_a: assert property (smp_stb && mux_mode && fast && !smp_last
    |-> ##200 smp_stb)
    else $error("fast slot spacing wrong");
  ascend_a: assert property (smp_stb && smp_ok && mux_mode && prev_reg[2]
    |-> smp_chan > prev_reg[1:0])
    else $error("channels out of ascending order");
  chan_sel_a: assert property (smp_stb && smp_ok && mux_mode
    |-> chans[smp_chan])
    else $error("valid sample of unselected channel");
  slow_valid_a: assert property (smp_stb && mux_mode && !fast && chans != 4'h0
    |-> smp_ok)
    else $error("slow module returned invalid sample");
endmodule // seq_link_assertions

`default_nettype wire

// ---- bench/tb_top.sv ----
/*
  top bench: chassis end and module end joined by the link interface.
  assumes design files and seq_defs.svh are compiled first.
*/
`include "seq_defs.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import seq_pkg::*;

  // short slow slot keeps the run brief
  localparam int slow_cyc = 50;

  logic clk, reset, usr_start, usr_read, usr_mux, usr_fast, usr_lowlevel;
  logic [3:0] usr_chans;
  logic [`RATE_W-1:0] usr_rate;
  logic usr_stb, usr_busy;
  data_t usr_data;
  logic [1:0] usr_chan;
  wire logic osc;
  ain_t ain [`NCH];
  int fail_count, tests_run, cyc, t0, tp;
  int ch_q[$], t_q[$];
  data_t d_q[$];
  data_t hi;

  seq_link_if lnk();

  chassis_end i_chassis_end (.clk(clk), .reset(reset),
    .usr_start(usr_start), .usr_read(usr_read), .usr_chans(usr_chans),
    .usr_rate(usr_rate), .usr_mux(usr_mux), .usr_fast(usr_fast),
    .usr_lowlevel(usr_lowlevel), .usr_stb(usr_stb), .usr_data(usr_data),
    .usr_chan(usr_chan), .usr_busy(usr_busy), .link(lnk.host));

  // exported tick fed back as the imported one
  adc_module_end #(.osc_export(1'b1), .slow_conv_cyc(slow_cyc))
    i_adc_module_end (.clk(clk), .reset(reset), .link(lnk.dev),
    .osc_in(osc), .osc_out(osc), .ain(ain));

  seq_link_assertions i_seq_link_assertions (.clk(clk), .reset(reset),
    .start(lnk.start), .req(lnk.req), .chans(lnk.chans),
    .mux_mode(lnk.mux_mode), .fast(lnk.fast), .smp_stb(lnk.smp_stb),
    .smp_chan(lnk.smp_chan), .smp_ok(lnk.smp_ok), .smp_last(lnk.smp_last));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // collect user samples with their time since the read
  // falling edge: registered outputs have settled by then
  always @(negedge clk) begin
    if (usr_stb === 1'b1) begin
      ch_q.push_back(int'(usr_chan));
      t_q.push_back(cyc - t0);
      d_q.push_back(usr_data);
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic do_read(input logic [3:0] ch, input logic mux, fast, low);
    int n;
    n = 0;
    ch_q.delete();
    t_q.delete();
    d_q.delete();
    @(posedge clk);
    usr_chans <= ch;
    usr_mux <= mux;
    usr_fast <= fast;
    usr_lowlevel <= low;
    usr_read <= 1'b1;
    t0 = cyc;
    @(posedge clk);
    usr_read <= 1'b0;
    @(negedge clk);
    while (usr_busy === 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    check("read done", n < 5000, 1'b1);
  endtask

  task automatic mux_case(input logic [3:0] ch, input logic fast, low,
                          input int first);
    int k;
    int slot;
    k = 0;
    slot = fast ? `MUX_FAST_CYC : slow_cyc;
    do_read(ch, 1'b1, fast, low);
    check("mux count", ch_q.size(), $countones(ch));
    for (int i = 0; i < 4; i++) begin
      if (ch[i] && k < ch_q.size()) begin
        check("mux chan", ch_q[k], i);
        check("mux data", d_q[k], 32'h100 * i);
        if (k > 0)
          check("mux gap", t_q[k] - t_q[k-1], slot);
        k++;
      end
    end
    if (k > 0)
      check("mux first", t_q[0] >= first && t_q[0] < first + 12, 1);
  endtask

  initial begin
    logic [`RATE_W-1:0] rq [3];
    logic [8:0] dv [3];
    rq = '{18'h0BEBC, 18'h0EA60, 18'h30D40};
    dv = '{`DIV_LO, `DIV_MID, `DIV_HI};
    reset = 1'b1;
    usr_start = 1'b0;
    usr_read = 1'b0;
    usr_chans = 4'h0;
    usr_rate = '0;
    usr_mux = 1'b0;
    usr_fast = 1'b0;
    usr_lowlevel = 1'b0;
    cyc = 0;
    t0 = 0;
    fail_count = 0;
    tests_run = 0;
    foreach (ain[i]) ain[i] = ain_t'(12'h100 * i);
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    do_read(4'h1, 1'b0, 1'b0, 1'b0);
    check("read before start", ch_q.size(), 0);
    // low, between, above top: exact, rounded up, clamped
    for (int r = 0; r < 3; r++) begin
      @(posedge clk);
      usr_rate <= rq[r];
      usr_start <= 1'b1;
      @(posedge clk);
      usr_start <= 1'b0;
      repeat (3) begin
        do_read(4'h1, 1'b0, 1'b0, 1'b0);
        check("early word", ch_q.size(), 0);
      end
      ain[0] <= 12'sh7FF;
      do_read(4'h1, 1'b0, 1'b0, 1'b0);
      check("os word", ch_q.size(), 1);
      check("os chan", ch_q[0], 0);
      tp = t_q[0] + t0;
      hi = d_q[0];
      ain[0] <= 12'sh800;
      do_read(4'h1, 1'b0, 1'b0, 1'b0);
      check("os period", t_q[0] + t0 - tp, 4 * dv[r]);
      check("os range", hi <= 16'(dv[r]), 1);
      check("os level", hi > d_q[0], 1);
    end
    // back to the ramp so mux data is known per channel
    ain[0] <= 12'sh000;
    mux_case(4'h5, 1'b1, 1'b0, 600);
    mux_case(4'h5, 1'b1, 1'b0, 200);
    mux_case(4'hC, 1'b1, 1'b0, 600);
    mux_case(4'h3, 1'b1, 1'b1, 600);
    mux_case(4'hF, 1'b1, 1'b0, 200);
    mux_case(4'hA, 1'b0, 1'b0, slow_cyc);
    mux_case(4'h0, 1'b1, 1'b0, 0);
    give_verdict();
  end

  // whole run needs about 13k cycles
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
